// *** longline_pkg.sv ***
package longline_pkg;

    // Array geometry: routing rows and columns and drivers per row.
    localparam int NUM_ROWS         = 4;
    localparam int NUM_COLS         = 4;
    localparam int VLINES_PER_COL   = 3;
    localparam int HLINES_PER_ROW   = 2;
    localparam int BUFS_PER_BLOCK   = 2;
    localparam int BUFS_PER_ROW     = NUM_COLS * BUFS_PER_BLOCK;
    localparam int NUM_BLOCKS       = NUM_ROWS * NUM_COLS;

    // Reset values.
    localparam logic KEEP_RESET     = 1'h1;
    localparam logic DIV_RESET      = 1'h0;

    // Clock source choice for one logic block clock input.
    typedef enum logic [1:0] {
        CLK_SRC_GLOBAL,
        CLK_SRC_ALT,
        CLK_SRC_ROUTED,
        CLK_SRC_NONE
    } clk_src_t;

    // One 3-state driver onto a horizontal long line.
    typedef struct packed {
        logic data;
        logic ctrl_n;   // Low enables the driver.
    } tbuf_t;

    // Oscillator path configuration.
    typedef struct packed {
        logic osc_enable;
        logic div2_enable;
    } osc_cfg_t;

endpackage

// *** hline_resolve.sv ***
`timescale 1ns/1ps

// Resolves one horizontal long line from its 3-state drivers, end pull-ups
// and weak keeper. Drivers are modelled as enables, never as high impedance.
module hline_resolve (
    input  wire logic                                         clk,
    input  wire logic                                         resetn,
    input  wire longline_pkg::tbuf_t [longline_pkg::BUFS_PER_ROW-1:0] drv,
    input  wire logic                                         pullup_en,
    output logic                                              line,
    output logic                                              contention
);

    logic any_low;
    logic any_high;
    logic keep;
    logic next_keep;

    always_comb begin
        any_low  = 1'b0;
        any_high = 1'b0;
        for (int i = 0; i < longline_pkg::BUFS_PER_ROW; i++) begin
            if (!drv[i].ctrl_n) begin
                any_low  = any_low | ~drv[i].data;
                any_high = any_high | drv[i].data;
            end
        end
    end

    always_comb begin
        contention = any_low & any_high;
        if (contention) begin
            line = 1'bx;    // Disagreeing drivers give an unknown in simulation.
        end else if (any_low) begin
            line = 1'b0;
        end else if (any_high) begin
            line = 1'b1;
        end else if (pullup_en) begin
            line = 1'b1;
        end else begin
            line = keep;
        end
    end

    // The keeper only tracks clean levels so an unknown never gets latched.
    always_comb begin
        next_keep = contention ? keep : line;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            keep <= longline_pkg::KEEP_RESET;
        end else begin
            keep <= next_keep;
        end
    end

    property p_low_wins;
        @(posedge clk) disable iff (!resetn)
        (any_low && !any_high) |-> (line == 1'b0);
    endproperty
    a_low_wins: assert property (p_low_wins) else $error("Low drive lost.");

    property p_high_wins;
        @(posedge clk) disable iff (!resetn)
        (any_high && !any_low) |-> line;
    endproperty
    a_high_wins: assert property (p_high_wins) else $error("High drive lost.");

    property p_pull_high;
        @(posedge clk) disable iff (!resetn)
        (!any_low && !any_high && pullup_en) |-> line;
    endproperty
    a_pull_high: assert property (p_pull_high) else $error("Pull-up lost.");

    // keeper holds level
    // The past reset guard keeps the reset value of the keeper out of the check.
    property p_keeper;
        @(posedge clk) disable iff (!resetn)
        ($past(resetn) && !any_low && !any_high && !pullup_en && !$past(contention))
        |-> (line == $past(line));
    endproperty
    a_keeper: assert property (p_keeper) else $error("Keeper lost level.");

endmodule

// *** longline_fabric.sv ***
`timescale 1ns/1ps

// Overview of operation
// - Three vertical, two horizontal lines each.
// - Block outputs drive vertical lines per column.
// - Global buffer can clock every logic block.
// - Per-block bits choose clock source.
// - Global net optionally drives edge clocks.
// - Alternate buffer feeds one vertical per column.
// - Two 3-state buffers drive when Low.
// - Shared data/control forms wired-AND.
// - End pull-ups read High when idle.
// - Weak keeper holds last driven level.
// - Optional oscillator divide-by-two for symmetry.
// - Oscillator connects only after configuration.
module longline_fabric (
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire logic                      global_clk_in,
    input  wire logic                      alt_clk_in,
    input  wire logic                      osc_in,
    input  wire logic                      config_done,
    input  wire longline_pkg::osc_cfg_t    osc_cfg,
    input  wire logic                      edge_clk_en,
    input  wire longline_pkg::tbuf_t [longline_pkg::NUM_ROWS*longline_pkg::BUFS_PER_ROW-1:0] tbuf,
    input  wire logic [longline_pkg::NUM_ROWS-1:0] pullup_en,
    input  wire logic [longline_pkg::NUM_COLS*longline_pkg::VLINES_PER_COL-1:0] vdrv_en,
    input  wire logic [longline_pkg::NUM_COLS*longline_pkg::VLINES_PER_COL-1:0] vdrv_data,
    input  wire logic [longline_pkg::NUM_COLS-1:0] alt_col_en,
    input  wire logic [longline_pkg::NUM_BLOCKS*2-1:0] clk_sel,
    input  wire logic [longline_pkg::NUM_BLOCKS-1:0] routed_clk,
    output logic [longline_pkg::NUM_ROWS*longline_pkg::HLINES_PER_ROW-1:0] hline,
    output logic [longline_pkg::NUM_ROWS-1:0] hline_contention,
    output logic [longline_pkg::NUM_COLS*longline_pkg::VLINES_PER_COL-1:0] vline,
    output logic [longline_pkg::NUM_BLOCKS-1:0] block_clk,
    output logic                           edge_clk,
    output logic                           osc_out
);

    localparam int VL = longline_pkg::VLINES_PER_COL;
    localparam int BR = longline_pkg::BUFS_PER_ROW;

    // Field width of one clock choice, the column line that can host the alternate
    // net, and the row whose second line carries that net.
    localparam int SEL_W  = $bits(longline_pkg::clk_src_t);
    localparam int ALT_VL = VL - 1;
    localparam int LAST_R = longline_pkg::NUM_ROWS - 1;

    logic global_net;
    logic alt_net;
    logic div_q;
    logic next_div_q;
    logic osc_src;

    always_comb begin
        next_div_q = osc_cfg.div2_enable ? ~div_q : longline_pkg::DIV_RESET;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= longline_pkg::DIV_RESET;
        end else begin
            div_q <= next_div_q;
        end
    end

    always_comb begin
        osc_src = osc_cfg.div2_enable ? div_q : osc_in;
        osc_out = osc_cfg.osc_enable & config_done & osc_src;
    end

    always_comb begin
        global_net = global_clk_in;
        alt_net    = alt_clk_in;
        edge_clk   = edge_clk_en & global_net;
    end

    genvar r;
    generate
        for (r = 0; r < longline_pkg::NUM_ROWS; r++) begin : g_row
            logic bus_line;
            hline_resolve u_bus (
                .clk        (clk),
                .resetn     (resetn),
                .drv        (tbuf[r*BR +: BR]),
                .pullup_en  (pullup_en[r]),
                .line       (bus_line),
                .contention (hline_contention[r])
            );
            // The second line of a row carries the alternate clock on the last row.
            assign hline[r*longline_pkg::HLINES_PER_ROW]     = bus_line;
            assign hline[r*longline_pkg::HLINES_PER_ROW + 1] =
                (r == longline_pkg::NUM_ROWS - 1) ? alt_net : bus_line;

            if (r == LAST_R) begin : g_alt
                property p_alt_row;
                    @(posedge clk) disable iff (!resetn)
                    hline[r*longline_pkg::HLINES_PER_ROW + 1] == alt_net;
                endproperty
                a_alt_row: assert property (p_alt_row) else $error("Alternate row lost.");
            end else begin : g_pair
                // both row lines agree
                // A clash leaves the line unknown, so the check waits for a clean bus.
                property p_row_pair;
                    @(posedge clk) disable iff (!resetn)
                    !hline_contention[r] |-> (hline[r*longline_pkg::HLINES_PER_ROW + 1]
                                              == hline[r*longline_pkg::HLINES_PER_ROW]);
                endproperty
                a_row_pair: assert property (p_row_pair) else $error("Row lines differ.");
            end
        end
    endgenerate

    genvar c;
    generate
        for (c = 0; c < longline_pkg::NUM_COLS; c++) begin : g_col
            // Line 0 takes block drive, line 1 too, line 2 can take the alternate net.
            assign vline[c*VL]     = vdrv_en[c*VL] & vdrv_data[c*VL];
            assign vline[c*VL + 1] = vdrv_en[c*VL + 1] & vdrv_data[c*VL + 1];
            assign vline[c*VL + ALT_VL] = alt_col_en[c] ? alt_net
                                        : (vdrv_en[c*VL + ALT_VL] & vdrv_data[c*VL + ALT_VL]);

            property p_vdrive;
                @(posedge clk) disable iff (!resetn)
                vdrv_en[c*VL] |-> (vline[c*VL] == vdrv_data[c*VL]);
            endproperty
            a_vdrive: assert property (p_vdrive) else $error("Column drive lost.");

            // alternate reaches column
            // The alternate connection overrides block drive on that line by choice.
            property p_alt_col;
                @(posedge clk) disable iff (!resetn)
                alt_col_en[c] |-> (vline[c*VL + ALT_VL] == alt_net);
            endproperty
            a_alt_col: assert property (p_alt_col) else $error("Alternate net missing.");
        end
    endgenerate

    genvar b;
    generate
        for (b = 0; b < longline_pkg::NUM_BLOCKS; b++) begin : g_blk
            longline_pkg::clk_src_t sel;
            assign sel = longline_pkg::clk_src_t'(clk_sel[b*SEL_W +: SEL_W]);
            always_comb begin
                case (sel)
                    longline_pkg::CLK_SRC_GLOBAL: block_clk[b] = global_net;
                    longline_pkg::CLK_SRC_ALT:    block_clk[b] = alt_net;
                    longline_pkg::CLK_SRC_ROUTED: block_clk[b] = routed_clk[b];
                    default:                      block_clk[b] = 1'b0;
                endcase
            end

            property p_gsel;
                @(posedge clk) disable iff (!resetn)
                (sel == longline_pkg::CLK_SRC_GLOBAL) |-> (block_clk[b] == global_net);
            endproperty
            a_gsel: assert property (p_gsel) else $error("Global clock not selected.");

            property p_asel;
                @(posedge clk) disable iff (!resetn)
                (sel == longline_pkg::CLK_SRC_ALT) |-> (block_clk[b] == alt_net);
            endproperty
            a_asel: assert property (p_asel) else $error("Alternate clock not selected.");

            property p_rsel;
                @(posedge clk) disable iff (!resetn)
                (sel == longline_pkg::CLK_SRC_ROUTED) |-> (block_clk[b] == routed_clk[b]);
            endproperty
            a_rsel: assert property (p_rsel) else $error("Routed clock not selected.");
        end
    endgenerate

    // no output before done
    // The oscillator may already run here; only its connection is held back.
    property p_osc_gate;
        @(posedge clk) disable iff (!resetn)
        !config_done |-> !osc_out;
    endproperty
    a_osc_gate: assert property (p_osc_gate) else $error("Oscillator before done.");

    property p_osc_pass;
        @(posedge clk) disable iff (!resetn)
        (config_done && osc_cfg.osc_enable && !osc_cfg.div2_enable) |-> (osc_out == osc_in);
    endproperty
    a_osc_pass: assert property (p_osc_pass) else $error("Oscillator path lost.");

    // divider toggles each edge
    // The past reset guard skips the edge at which the divider leaves reset.
    property p_div;
        @(posedge clk) disable iff (!resetn)
        ($past(resetn) && osc_cfg.div2_enable && $past(osc_cfg.div2_enable))
        |-> (div_q != $past(div_q));
    endproperty
    a_div: assert property (p_div) else $error("Divider stuck.");

    property p_edge;
        @(posedge clk) disable iff (!resetn)
        !edge_clk_en |-> !edge_clk;
    endproperty
    a_edge: assert property (p_edge) else $error("Edge clock leak.");

    property p_edge_on;
        @(posedge clk) disable iff (!resetn)
        edge_clk_en |-> (edge_clk == global_net);
    endproperty
    a_edge_on: assert property (p_edge_on) else $error("Edge clock lost.");

endmodule

// *** bus_drivers.sv ***
`timescale 1ns/1ps

// Logic blocks on every row driving the shared long lines.
module bus_drivers (
    input  wire logic                        en,
    input  wire logic [31:0]                 bus_en,
    input  wire logic [3:0]                  val,
    input  wire logic                        wired_and,
    input  wire logic                        clash,
    output longline_pkg::tbuf_t [31:0]       tbuf
);
    // agreeing drivers unless clash flips driver 1 of each row; wired_and overrides the flip
    // Outside wired_and an idle driver shows the inverse level, so a leak past ctrl_n is seen.
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            tbuf[i].ctrl_n = ~(en & bus_en[i]);
            tbuf[i].data   = tbuf[i].ctrl_n ? ~val[i/8] : val[i/8] ^ (clash && i % 8 == 1);
            if (wired_and) begin
                tbuf[i].data = tbuf[i].ctrl_n;
            end
        end
    end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
    logic                         clk = 0, resetn = 0, gclk, aclk, osc, cfg_done, edge_en;
    logic                         wired_and, clash, eclk, oout, ref_div, lvl, any_d;
    longline_pkg::osc_cfg_t       ocfg;
    longline_pkg::tbuf_t [31:0]   tbuf;
    logic [31:0]                  bus_en, sel;
    logic [15:0]                  rclk, bclk;
    logic [11:0]                  ven, vdat, vline;
    logic [7:0]                   hline;
    logic [3:0]                   val, pu, acol, hcon, keep, exp_l, exp_c;
    int                           fails = 0, comparisons = 0;

    // Free-running sample clock.
    always #5 clk = ~clk;

    bus_drivers bus_drivers_inst (.en(resetn), .bus_en(bus_en), .val(val), .wired_and(wired_and),
        .clash(clash), .tbuf(tbuf));
    longline_fabric longline_fabric_inst (.clk(clk), .resetn(resetn), .global_clk_in(gclk),
        .alt_clk_in(aclk), .osc_in(osc), .config_done(cfg_done), .osc_cfg(ocfg),
        .edge_clk_en(edge_en), .tbuf(tbuf), .pullup_en(pu), .vdrv_en(ven), .vdrv_data(vdat),
        .alt_col_en(acol), .clk_sel(sel), .routed_clk(rclk), .hline(hline),
        .hline_contention(hcon), .vline(vline), .block_clk(bclk), .edge_clk(eclk),
        .osc_out(oout));

    // Reference bus: any active driver wins, then the pull-up, then the keeper.
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            exp_c[r] = 0;
            any_d = 0;
            lvl = 0;
            for (int j = 0; j < 8; j++) begin
                if (!tbuf[r*8+j].ctrl_n) begin
                    if (any_d && tbuf[r*8+j].data != lvl) exp_c[r] = 1;
                    any_d = 1;
                    lvl = tbuf[r*8+j].data;
                end
            end
            exp_l[r] = any_d ? lvl : (pu[r] ? 1'b1 : keep[r]);
        end
    end

    // Reference keeper; a clash leaves the previous clean level in place.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) keep <= 4'hf;
        else for (int r = 0; r < 4; r++) if (!exp_c[r]) keep[r] <= exp_l[r];
    end

    // Reference divider: toggles on every sample edge while divide-by-two is on.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) ref_div <= 1'b0;
        else ref_div <= ocfg.div2_enable ? ~ref_div : 1'b0;
    end

    task automatic check(input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Compare outputs at the falling edge, skipping clashing row lines and undriven column lines, then apply fresh inputs.
    initial begin
        {gclk, aclk, osc, cfg_done, edge_en, wired_and, clash, ocfg} = 0;
        {bus_en, sel, rclk, ven, vdat, val, pu, acol} = 0;
        void'($urandom(32'hac19af15));
        repeat (6) @(posedge clk);
        @(negedge clk) resetn = 1;
        for (int n = 0; n < 600; n++) begin
            @(negedge clk);
            for (int r = 0; r < 4; r++) begin
                if (!exp_c[r]) check(hline[r*2], exp_l[r]);
                if (!exp_c[r]) check(hline[r*2+1], r == 3 ? aclk : exp_l[r]);
                check(hcon[r], exp_c[r]);
            end
            for (int b = 0; b < 16; b++) begin
                check(bclk[b], sel[2*b+:2] == 0 ? gclk : sel[2*b+:2] == 1 ? aclk :
                      sel[2*b+:2] == 2 ? rclk[b] : 1'b0);
            end
            for (int v = 0; v < 12; v++) begin
                if (v % 3 == 2 && acol[v/3]) check(vline[v], aclk);
                else if (ven[v]) check(vline[v], vdat[v]);
            end
            check(eclk, edge_en & gclk);
            if (!(cfg_done && ocfg.osc_enable)) check(oout, 1'b0);
            else if (!ocfg.div2_enable) check(oout, osc);
            else check(oout, ref_div);
            {gclk, aclk, osc, edge_en} = 4'($urandom);
            {val, pu, acol} = 12'($urandom);
            {ven, vdat, rclk} = 40'({$urandom, $urandom});
            sel = $urandom;
            bus_en = ($urandom % 3 == 0) ? 32'h0 : $urandom & $urandom;
            wired_and = ($urandom % 4 == 0);
            clash = ($urandom % 8 == 0);
            if (n % 8 == 0) {cfg_done, ocfg} = 3'($urandom);
        end
        end_of_test();
    end
endmodule
